//--- hdl/sas_pkg.sv
// Constants for the serial register-access front end
package sas_pkg;
  localparam int          ADDR_W        = 7;
  localparam int          UPPER_W       = 3;
  localparam int          LOWER_W       = 4;
  localparam int          BYTE_W        = 8;
  localparam int          SYNC_STAGES   = 2;
  // First instruction byte: bit 7 read, bits 6:5 kind, bit 4 one, bits 3:0 marker
  localparam int          INST_RW_BIT   = 7;
  localparam logic [1:0]  KIND_UPPER    = 2'h0;
  localparam logic [1:0]  KIND_ACCESS   = 2'h1;
  // Upper setup payload: bits 2:0 upper part
  // Second instruction byte: bit 7 read, bits 6:5 size, bits 3:0 lower part
  localparam int          SIZE_HI       = 6;
  localparam int          SIZE_LO       = 5;
  localparam logic [1:0]  SIZE_STREAM   = 2'h3;
  localparam logic [2:0]  UPPER_RESET   = 3'h0;
  localparam logic [6:0]  ADDR_TOP      = 7'h7f;
  localparam logic [6:0]  ADDR_ZERO     = 7'h00;
  localparam logic [2:0]  BIT_LAST      = 3'h7;
  localparam logic [2:0]  BIT_FIRST     = 3'h0;
  typedef enum logic [1:0] {
    SAS_INST1 = 2'b00,
    SAS_UPPER = 2'b01,
    SAS_SECOND_INSTRUCTION_BYTE = 2'b10,
    SAS_DATA  = 2'b11
  } sas_state_t;
endpackage

//--- hdl/sas_spi_regaccess.sv
// Serial slave front end for seven-bit register access with streaming
`timescale 1ns/1ns
module sas_spi_regaccess
  import sas_pkg::*;
(
  // Clock and reset
  input  wire logic               sys_clk_in,
  input  wire logic               rst_n_in,
  // Serial pins
  input  wire logic               chip_select_low_in,
  input  wire logic               sclk_in,
  input  wire logic               sdi_in,
  input  wire logic               data_ready_low_in,
  output logic                    sdo_out,
  output logic                    sdo_oe_n_out,
  // Stream control
  input  wire logic               stream_kind_bit_in,
  input  wire logic [ADDR_W-1:0]  stream_span_field_in,
  // Register file side
  output logic [ADDR_W-1:0]       reg_addr_out,
  output logic [BYTE_W-1:0]       reg_wdata_out,
  output logic                    reg_wr_out,
  output logic                    reg_rd_out,
  input  wire logic [BYTE_W-1:0]  reg_rdata_in,
  // Status
  output logic [UPPER_W-1:0]      upper_address_part_out,
  output logic                    busy_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Reset to idle pin levels so no false edge follows
  logic [SYNC_STAGES-1:0] cs_sync_reg;
  logic [SYNC_STAGES-1:0] sck_sync_reg;
  logic [SYNC_STAGES-1:0] sdi_sync_reg;
  logic                   sck_prev_reg;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cs_sync_reg  <= '1;
      sck_sync_reg <= '0;
      sdi_sync_reg <= '0;
      sck_prev_reg <= 1'b0;
    end else begin
      cs_sync_reg  <= {cs_sync_reg[0], chip_select_low_in};
      sck_sync_reg <= {sck_sync_reg[0], sclk_in};
      sdi_sync_reg <= {sdi_sync_reg[0], sdi_in};
      sck_prev_reg <= sck_sync_reg[1];
    end
  end

  logic cs_active;
  logic sck_rise;
  logic sck_fall;
  logic sdi_bit;
  assign cs_active = ~cs_sync_reg[1];
  assign sck_rise  = cs_active & sck_sync_reg[1] & ~sck_prev_reg;
  assign sck_fall  = cs_active & ~sck_sync_reg[1] & sck_prev_reg;
  assign sdi_bit   = sdi_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Bit shifter
  sas_state_t        state_reg;
  logic [2:0]        bit_cnt_reg;
  logic [BYTE_W-1:0] shift_in_reg;
  logic [BYTE_W-1:0] rx_byte;
  logic              byte_done;
  assign rx_byte   = {shift_in_reg[BYTE_W-2:0], sdi_bit};
  assign byte_done = sck_rise & (bit_cnt_reg == BIT_LAST);

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || !cs_active) begin
      bit_cnt_reg  <= BIT_FIRST;
      shift_in_reg <= '0;
    end else if (sck_rise) begin
      bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      shift_in_reg <= rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state
  logic              read_reg;
  logic              stream_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] start_reg;
  logic [ADDR_W-1:0] span_cnt_reg;
  logic [UPPER_W-1:0] upper_reg;
  logic [ADDR_W-1:0] addr_next;

  // Controlled stream returns to start after span plus one bytes
  always_comb begin
    addr_next = (addr_reg == ADDR_TOP) ? ADDR_ZERO : addr_reg + 7'h01;
    if (stream_kind_bit_in && span_cnt_reg == stream_span_field_in) begin
      addr_next = start_reg;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_reg    <= SAS_INST1;
      read_reg     <= 1'b0;
      stream_reg   <= 1'b0;
      addr_reg     <= ADDR_ZERO;
      start_reg    <= ADDR_ZERO;
      span_cnt_reg <= '0;
      upper_reg    <= UPPER_RESET;
    end else if (!cs_active) begin
      state_reg <= SAS_INST1;
    end else if (byte_done) begin
      case (state_reg)
        SAS_INST1: begin
          read_reg <= rx_byte[INST_RW_BIT];
          if (rx_byte[SIZE_HI:SIZE_LO] == KIND_UPPER) begin
            state_reg <= SAS_UPPER;
          end else if (rx_byte[SIZE_HI:SIZE_LO] == KIND_ACCESS) begin
            state_reg <= SAS_SECOND_INSTRUCTION_BYTE;
          end
        end
        SAS_UPPER: begin
          upper_reg <= rx_byte[UPPER_W-1:0];
          state_reg <= SAS_INST1;
        end
        SAS_SECOND_INSTRUCTION_BYTE: begin
          read_reg     <= rx_byte[INST_RW_BIT];
          stream_reg   <= (rx_byte[SIZE_HI:SIZE_LO] == SIZE_STREAM);
          addr_reg     <= {upper_reg, rx_byte[LOWER_W-1:0]};
          start_reg    <= {upper_reg, rx_byte[LOWER_W-1:0]};
          span_cnt_reg <= '0;
          state_reg    <= SAS_DATA;
        end
        SAS_DATA: begin
          if (stream_reg) begin
            addr_reg     <= addr_next;
            span_cnt_reg <= (addr_next == start_reg) ? '0 : span_cnt_reg + 7'h01;
          end else begin
            state_reg <= SAS_INST1;
          end
        end
        default: state_reg <= SAS_INST1;
      endcase
    end
  end

  // Held upper part never follows the streaming address
  assign upper_address_part_out = upper_reg;
  assign busy_out               = cs_active;

  ////////////////////////////////////////////////////////////////////////////
  // Register strobes and output shifter
  logic [BYTE_W-1:0] shift_out_reg;
  logic              load_pending_reg;
  // Read data is taken the cycle after the strobe; no shift
  // after the last bit, so the next byte can load in its place

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      reg_addr_out  <= ADDR_ZERO;
      reg_wdata_out <= '0;
      reg_wr_out    <= 1'b0;
      reg_rd_out    <= 1'b0;
    end else begin
      reg_wr_out <= byte_done && cs_active && state_reg == SAS_DATA && !read_reg;
      reg_rd_out <= byte_done && cs_active && !rx_byte[INST_RW_BIT] == 1'b0
                    && state_reg == SAS_SECOND_INSTRUCTION_BYTE
                    || (byte_done && cs_active && state_reg == SAS_DATA && read_reg && stream_reg);
      if (byte_done && state_reg == SAS_DATA) begin
        reg_wdata_out <= rx_byte;
        reg_addr_out  <= addr_reg;
      end
      if (byte_done && state_reg == SAS_SECOND_INSTRUCTION_BYTE) begin
        reg_addr_out <= {upper_reg, rx_byte[LOWER_W-1:0]};
      end else if (byte_done && state_reg == SAS_DATA && read_reg && stream_reg) begin
        reg_addr_out <= addr_next;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || !cs_active) begin
      shift_out_reg    <= '0;
      load_pending_reg <= 1'b0;
    end else if (reg_rd_out) begin
      load_pending_reg <= 1'b1;
    end else if (load_pending_reg) begin
      shift_out_reg    <= reg_rdata_in;
      load_pending_reg <= 1'b0;
    end else if (sck_fall && state_reg == SAS_DATA && bit_cnt_reg != BIT_FIRST) begin
      shift_out_reg <= {shift_out_reg[BYTE_W-2:0], 1'b0};
    end
  end

  // Shared pin: data during reads, data-ready level otherwise
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sdo_out      <= 1'b1;
      sdo_oe_n_out <= 1'b1;
    end else begin
      sdo_oe_n_out <= ~cs_active;
      sdo_out      <= (state_reg == SAS_DATA && read_reg) ? shift_out_reg[BYTE_W-1]
                                                           : data_ready_low_in;
    end
  end

endmodule

//--- tb/sas_sva.sv
// Checker for the serial register-access front end
`timescale 1ns/1ns
module sas_sva
  import sas_pkg::*;
(
  input wire logic               sys_clk_in,
  input wire logic               rst_n_in,
  input wire logic               sdo_oe_n_out,
  input wire logic               reg_wr_out,
  input wire logic               reg_rd_out,
  input wire logic [UPPER_W-1:0] upper_address_part_out,
  input wire logic               busy_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_rst;
    $rose(rst_n_in) |-> sdo_oe_n_out && upper_address_part_out == UPPER_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_wr; reg_wr_out |=> !reg_wr_out [*8]; endproperty
  a_wr: assert property (p_wr) else $error("write strobe too long");
  property p_rd; reg_rd_out |=> !reg_rd_out [*8]; endproperty
  a_rd: assert property (p_rd) else $error("read strobe too long");
  property p_sel; reg_wr_out |-> $past(busy_out, 2); endproperty
  a_sel: assert property (p_sel) else $error("write outside frame");
  property p_hold; !busy_out && $past(!busy_out) |-> $stable(upper_address_part_out); endproperty
  a_hold: assert property (p_hold) else $error("upper part moved idle");
  property p_rel; $fell(busy_out) |-> ##[0:3] sdo_oe_n_out; endproperty
  a_rel: assert property (p_rel) else $error("output not released");
  property p_quiet; !busy_out [*2] |-> sdo_oe_n_out; endproperty
  a_quiet: assert property (p_quiet) else $error("driving while idle");
  property p_drv; busy_out [*4] |-> !sdo_oe_n_out; endproperty
  a_drv: assert property (p_drv) else $error("not driving in frame");
  c_wr: cover property (reg_wr_out);
  c_rd: cover property (reg_rd_out);
  c_up: cover property ($changed(upper_address_part_out));
endmodule
bind sas_spi_regaccess sas_sva u_sas_sva (.sys_clk_in, .rst_n_in, .sdo_oe_n_out,
  .reg_wr_out, .reg_rd_out, .upper_address_part_out, .busy_out);

//--- tb/sas_spi_master.sv
// Behavioural serial master on the far side of the pins
`timescale 1ns/1ns
module sas_spi_master (
  output logic      chip_select_low_out,
  output logic      sclk_out,
  output logic      sdi_out,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_n_in
);
  initial begin
    chip_select_low_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end
  // Select never tied, so streams always end on deselect
  task automatic frame(input logic on);
    #400;
    chip_select_low_out = !on;
    #400;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi_out = tx[i];
      #200 sclk_out = 1'b1;
      rx[i] = sdo_oe_n_in ? 1'bx : sdo_in;
      // Inverse after the hold time exposes late sampling
      #100 sdi_out = !tx[i];
      #100 sclk_out = 1'b0;
    end
  endtask
endmodule

//--- tb/sas_spi_regaccess_tb.sv
// Self-checking bench for the serial register-access front end
`timescale 1ns/1ns
module sas_spi_regaccess_tb;
  import sas_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        cs_low, sclk, sdi, sdo, oe_n, rd, wr, busy;
  logic        kind;
  logic        dry;
  logic [6:0]  span;
  logic [6:0]  addr;
  logic [7:0]  wdata, rx;
  logic [7:0]  rdata;
  logic [2:0]  upper, eu;
  logic [7:0]  mem [128];
  logic [14:0] wq [$];
  int          mismatches = 0;
  int          samples_checked = 0;
  always #25 sys_clk_in = !sys_clk_in;
  sas_spi_regaccess u_sas_spi_regaccess (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .chip_select_low_in(cs_low), .sclk_in(sclk), .sdi_in(sdi), .data_ready_low_in(dry),
    .sdo_out(sdo), .sdo_oe_n_out(oe_n), .stream_kind_bit_in(kind),
    .stream_span_field_in(span), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata),
    .upper_address_part_out(upper), .busy_out(busy));
  sas_spi_master u_sas_spi_master (.chip_select_low_out(cs_low), .sclk_out(sclk),
    .sdi_out(sdi), .sdo_in(sdo), .sdo_oe_n_in(oe_n));
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Register file beside the block
  always @(posedge sys_clk_in) begin
    if (rd)
      rdata <= mem[addr];
    if (wr) begin
      chk({addr, wdata}, wq.size() != 0 ? wq.pop_front() : 15'h7fff);
      mem[addr] <= wdata;
    end
  end
  always @(negedge sys_clk_in) dry <= 1'($urandom);
  task automatic setup(input logic [2:0] u);
    u_sas_spi_master.xfer(8'h10, rx);
    u_sas_spi_master.xfer({5'h0, u}, rx);
    eu = u;
  endtask
  task automatic acc(input logic r, input logic [3:0] lo, input int n);
    logic [6:0] a;
    logic [7:0] d;
    u_sas_spi_master.xfer({r, 7'h30}, rx);
    u_sas_spi_master.xfer({r, (n > 1 ? SIZE_STREAM : 2'h0), 1'b0, lo}, rx);
    for (int k = 0; k < n; k++) begin
      a = {eu, lo} + 7'(kind ? k % (span + 1) : k);
      d = 8'($urandom);
      if (!r)
        wq.push_back({a, d});
      u_sas_spi_master.xfer(d, rx);
      if (r)
        chk({7'h0, rx}, {7'h0, mem[a]});
    end
  endtask
  initial begin
    void'($urandom(32'hce6a));
    kind = 1'b0;
    span = 7'h0;
    for (int i = 0; i < 128; i++)
      mem[i] = 8'($urandom);
    repeat (3) @(posedge sys_clk_in);
    @(negedge sys_clk_in) rst_n_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    u_sas_spi_master.frame(1'b1);
    setup(3'h7);
    acc(1'b0, 4'hf, 1);
    acc(1'b0, 4'he, 4);
    u_sas_spi_master.frame(1'b0);
    chk({12'h0, upper}, {12'h0, eu});
    $display("test normal stream done");
    @(negedge sys_clk_in);
    kind = 1'b1;
    span = 7'($urandom_range(1, 3));
    u_sas_spi_master.frame(1'b1);
    acc(1'b1, 4'he, 2 * span + 3);
    u_sas_spi_master.frame(1'b0);
    $display("test controlled stream done");
    u_sas_spi_master.frame(1'b1);
    u_sas_spi_master.xfer(8'h50, rx);
    setup(3'h1);
    acc(1'b1, 4'h2, 1);
    u_sas_spi_master.frame(1'b0);
    chk({12'h0, upper}, {12'h0, eu});
    $display("test refused kind done");
    conclude;
  end
  initial begin
    #1000000;
    mismatches++;
    conclude;
  end
endmodule
